// ---- src/iopfr_bank.sv ----
`timescale 1ns/1ps
`include "iopfr_regs.svh"
// Functional notes
// - Sixteen-bit mask selects terminals 0..15 for a timed on-pulse.
// - Nonzero duration write starts pulse; counts down per millisecond, readable.
// - Tagged terminals driven on while counting, turned off at expiry.
// - Duration zero holds tagged outputs off.
// - Error summary bit n is OR of all fault logs for terminal n.
// - Under-current bit follows fault live on solenoid terminals, auto-clears.
// - Over-current bit sticky on solenoid terminals until software clears.
// - Writable low threshold in mA flags under-current when current below.
// - Writable high threshold in mA flags over-current when current above.
// - Sixteen up timers count whole seconds at 1; write resets.
// - Sixteen down timers count whole seconds at 0; write resets.
// - Sixteen writable solenoid pulse durations in ms, first is terminal 0.
// - Sixteen writable solenoid on/off durations in seconds from base.
// - Read-only supply voltage in millivolts.
// - Current draw in mA; zero when no sensor fitted.
// - Temperature in degrees C as signed 16-bit value.
// - Read-only merged word of input and output terminal states.
// - Down timer held at zero while terminal bit is 1.
module iopfr_bank
    import iopfr_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `IOPFR_MS_NS / `IOPFR_CLK_NS
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    output logic reg_exc,
    input wire logic [15:0] io_pin_in,
    input wire logic [15:0] io_out_req,
    input wire logic [15:0] io_is_output,
    input wire logic [15:0] solenoid_terms,
    input wire logic [255:0] term_current_ma,
    input wire logic [15:0] supply_mv,
    input wire logic [15:0] draw_ma,
    input wire logic current_sensor_present,
    input wire logic [15:0] temp_c,
    output logic [15:0] io_drive,
    output logic [255:0] sol_pulse_ms,
    output logic [255:0] sol_onoff_s
);

    // ------------------------------------------------------------
    // Address decode helper
    // ------------------------------------------------------------

    // Hit flag and index for a 16-entry table
    function automatic iopfr_slot_t slot(input logic [15:0] a, input logic [15:0] base);
        logic [15:0] d;
        d = a - base;
        slot = (d < `IOPFR_TBL_SPAN) ? {1'b1, d[3:0]} : 5'h00;
    endfunction : slot

    iopfr_slot_t up_slot;
    iopfr_slot_t dn_slot;
    iopfr_slot_t solms_slot;
    iopfr_slot_t sols_slot;
    assign up_slot = slot(reg_addr, `IOPFR_ADDR_UP_BASE);
    assign dn_slot = slot(reg_addr, `IOPFR_ADDR_DN_BASE);
    assign solms_slot = slot(reg_addr, `IOPFR_ADDR_SOL_MS_BASE);
    assign sols_slot = slot(reg_addr, `IOPFR_ADDR_SOL_S_BASE);

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    iopfr_word_t io_meta;
    iopfr_word_t io_sync;

    // Two-stage capture of terminal inputs
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            io_meta <= `IOPFR_ZERO;
            io_sync <= `IOPFR_ZERO;
        end else begin
            io_meta <= io_pin_in;
            io_sync <= io_meta;
        end
    end

    // ------------------------------------------------------------
    // Millisecond time base
    // ------------------------------------------------------------
    logic [`IOPFR_MS_CNT_W-1:0] ms_cnt;
    logic ms_tick;
    logic pulse_wr;
    localparam logic [`IOPFR_MS_CNT_W-1:0] MS_LAST = `IOPFR_MS_CNT_W'(MS_CYCLES - 1);

    assign ms_tick = (ms_cnt == MS_LAST);
    assign pulse_wr = reg_wr && (reg_addr == `IOPFR_ADDR_PULSE_MS);

    // Free-running, restarted by a duration write for a full first ms
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ms_cnt <= '0;
        end else if (pulse_wr || ms_tick) begin
            ms_cnt <= '0;
        end else begin
            ms_cnt <= ms_cnt + `IOPFR_MS_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Timed pulse
    // ------------------------------------------------------------
    iopfr_word_t pulse_mask;
    iopfr_word_t pulse_ms;
    iopfr_word_t next_io_drive;

    // Pulse mask register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pulse_mask <= `IOPFR_ZERO;
        end else if (reg_wr && (reg_addr == `IOPFR_ADDR_PULSE_MASK)) begin
            pulse_mask <= reg_wdata;
        end
    end

    // Countdown: load on write, step down each ms, rest at zero
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pulse_ms <= `IOPFR_ZERO;
        end else if (pulse_wr) begin
            pulse_ms <= reg_wdata;
        end else if (ms_tick && (pulse_ms != `IOPFR_ZERO)) begin
            pulse_ms <= pulse_ms - 16'h0001;
        end
    end

    // Tagged terminals on while counting, off otherwise
    always_comb begin
        next_io_drive = (io_out_req & ~pulse_mask)
                      | (pulse_mask & {`IOPFR_NTERM{pulse_ms != `IOPFR_ZERO}});
    end

    // Registered terminal drive
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            io_drive <= `IOPFR_ZERO;
        end else begin
            io_drive <= next_io_drive;
        end
    end

    // ------------------------------------------------------------
    // Merged terminal state
    // ------------------------------------------------------------
    iopfr_word_t io_state;
    iopfr_word_t io_state_q;

    assign io_state = (io_is_output & io_drive) | (~io_is_output & io_sync);

    // Previous state for rising-edge detection
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            io_state_q <= `IOPFR_ZERO;
        end else begin
            io_state_q <= io_state;
        end
    end

    // ------------------------------------------------------------
    // Current thresholds and fault logs
    // ------------------------------------------------------------
    iopfr_word_t low_thr;
    iopfr_word_t high_thr;
    iopfr_word_t uc_now;
    iopfr_word_t oc_now;
    iopfr_word_t uc_log;
    iopfr_word_t oc_log;
    iopfr_word_t oc_clr;
    iopfr_word_t err_sum;
    iopfr_word_t cur [`IOPFR_NTERM];

    // Threshold registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            low_thr <= `IOPFR_RST_LOW_THR;
            high_thr <= `IOPFR_RST_HIGH_THR;
        end else if (reg_wr) begin
            if (reg_addr == `IOPFR_ADDR_LOW_THR) begin
                low_thr <= reg_wdata;
            end
            if (reg_addr == `IOPFR_ADDR_HIGH_THR) begin
                high_thr <= reg_wdata;
            end
        end
    end

    // Per-terminal comparisons, solenoid terminals only
    for (genvar i = 0; i < `IOPFR_NTERM; i++) begin : g_cmp
        assign cur[i] = term_current_ma[i*`IOPFR_W +: `IOPFR_W];
        assign uc_now[i] = solenoid_terms[i] && (cur[i] < low_thr);
        assign oc_now[i] = solenoid_terms[i] && (cur[i] > high_thr);
    end

    assign oc_clr = (reg_wr && (reg_addr == `IOPFR_ADDR_OC_LOG)) ? reg_wdata : `IOPFR_ZERO;

    // Live under-current log
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            uc_log <= `IOPFR_ZERO;
        end else begin
            uc_log <= uc_now;
        end
    end

    // Sticky over-current log, new fault beats clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            oc_log <= `IOPFR_ZERO;
        end else begin
            oc_log <= (oc_log & ~oc_clr) | oc_now;
        end
    end

    assign err_sum = uc_log | oc_log;

    // ------------------------------------------------------------
    // Per-terminal seconds timers
    // ------------------------------------------------------------
    iopfr_ms_t up_ms [`IOPFR_NTERM];
    iopfr_ms_t dn_ms [`IOPFR_NTERM];
    iopfr_word_t up_s [`IOPFR_NTERM];
    iopfr_word_t dn_s [`IOPFR_NTERM];

    for (genvar i = 0; i < `IOPFR_NTERM; i++) begin : g_tmr
        logic up_hit;
        logic dn_hit;
        assign up_hit = reg_wr && up_slot[4] && (up_slot[3:0] == 4'(i));
        assign dn_hit = reg_wr && dn_slot[4] && (dn_slot[3:0] == 4'(i));

        // Up timer restarts on each rise, holds last on-time while low
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                up_ms[i] <= '0;
                up_s[i] <= `IOPFR_ZERO;
            end else if (up_hit || (io_state[i] && !io_state_q[i])) begin
                up_ms[i] <= '0;
                up_s[i] <= `IOPFR_ZERO;
            end else if (io_state[i] && ms_tick) begin
                if (up_ms[i] == `IOPFR_MS_LAST) begin
                    up_ms[i] <= '0;
                    up_s[i] <= up_s[i] + 16'h0001;
                end else begin
                    up_ms[i] <= up_ms[i] + 10'h001;
                end
            end
        end

        // Down timer held at zero while terminal is high
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                dn_ms[i] <= '0;
                dn_s[i] <= `IOPFR_ZERO;
            end else if (dn_hit || io_state[i]) begin
                dn_ms[i] <= '0;
                dn_s[i] <= `IOPFR_ZERO;
            end else if (ms_tick) begin
                if (dn_ms[i] == `IOPFR_MS_LAST) begin
                    dn_ms[i] <= '0;
                    dn_s[i] <= dn_s[i] + 16'h0001;
                end else begin
                    dn_ms[i] <= dn_ms[i] + 10'h001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Solenoid timing tables
    // ------------------------------------------------------------
    iopfr_word_t sol_ms [`IOPFR_NTERM];
    iopfr_word_t sol_s [`IOPFR_NTERM];

    for (genvar i = 0; i < `IOPFR_NTERM; i++) begin : g_sol
        // Table entry writes
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                sol_ms[i] <= `IOPFR_ZERO;
                sol_s[i] <= `IOPFR_ZERO;
            end else if (reg_wr) begin
                if (solms_slot[4] && (solms_slot[3:0] == 4'(i))) begin
                    sol_ms[i] <= reg_wdata;
                end
                if (sols_slot[4] && (sols_slot[3:0] == 4'(i))) begin
                    sol_s[i] <= reg_wdata;
                end
            end
        end
        assign sol_pulse_ms[i*`IOPFR_W +: `IOPFR_W] = sol_ms[i];
        assign sol_onoff_s[i*`IOPFR_W +: `IOPFR_W] = sol_s[i];
    end

    // ------------------------------------------------------------
    // Read mux and response
    // ------------------------------------------------------------
    iopfr_word_t next_rdata;
    logic rd_hit;
    logic wr_ok;

    // Read data selection
    always_comb begin
        next_rdata = `IOPFR_ZERO;
        rd_hit = 1'b1;
        if (up_slot[4]) begin
            next_rdata = up_s[up_slot[3:0]];
        end else if (dn_slot[4]) begin
            next_rdata = dn_s[dn_slot[3:0]];
        end else if (solms_slot[4]) begin
            next_rdata = sol_ms[solms_slot[3:0]];
        end else if (sols_slot[4]) begin
            next_rdata = sol_s[sols_slot[3:0]];
        end else begin
            unique case (reg_addr)
                `IOPFR_ADDR_PULSE_MASK: next_rdata = pulse_mask;
                `IOPFR_ADDR_PULSE_MS: next_rdata = pulse_ms;
                `IOPFR_ADDR_ERR_SUM: next_rdata = err_sum;
                `IOPFR_ADDR_UC_PRIMARY: next_rdata = uc_log;
                `IOPFR_ADDR_OC_LOG: next_rdata = oc_log;
                `IOPFR_ADDR_UC_LOG: next_rdata = uc_log;
                `IOPFR_ADDR_LOW_THR: next_rdata = low_thr;
                `IOPFR_ADDR_HIGH_THR: next_rdata = high_thr;
                `IOPFR_ADDR_SUPPLY_MV: next_rdata = supply_mv;
                `IOPFR_ADDR_DRAW_MA: begin
                    next_rdata = current_sensor_present ? draw_ma : `IOPFR_ZERO;
                end
                `IOPFR_ADDR_TEMP: next_rdata = temp_c;
                `IOPFR_ADDR_IO_STATE: next_rdata = io_state;
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // Writable addresses; readouts refuse writes
    assign wr_ok = rd_hit
                && (reg_addr != `IOPFR_ADDR_SUPPLY_MV)
                && (reg_addr != `IOPFR_ADDR_DRAW_MA)
                && (reg_addr != `IOPFR_ADDR_TEMP)
                && (reg_addr != `IOPFR_ADDR_IO_STATE);

    // One-cycle answer after each request
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata <= `IOPFR_ZERO;
            reg_ack <= 1'b0;
            reg_exc <= 1'b0;
        end else begin
            reg_ack <= (reg_rd && rd_hit) || (reg_wr && wr_ok);
            reg_exc <= (reg_rd && !rd_hit) || (reg_wr && !wr_ok);
            if (reg_rd && rd_hit) begin
                reg_rdata <= next_rdata;
            end
        end
    end

endmodule : iopfr_bank

// ---- src/iopfr_regs.svh ----
`ifndef IOPFR_REGS_SVH
`define IOPFR_REGS_SVH

// ----------------------------------------------------------------
// Register addresses (protocol register numbers)
// ----------------------------------------------------------------
`define IOPFR_ADDR_PULSE_MASK 16'h0A8C
`define IOPFR_ADDR_PULSE_MS 16'h0A8D
`define IOPFR_ADDR_ERR_SUM 16'h0B54
`define IOPFR_ADDR_UC_PRIMARY 16'h0B55
`define IOPFR_ADDR_OC_LOG 16'h0B56
`define IOPFR_ADDR_UC_LOG 16'h0B57
`define IOPFR_ADDR_LOW_THR 16'h0B58
`define IOPFR_ADDR_HIGH_THR 16'h0B59
`define IOPFR_ADDR_UP_BASE 16'h0CE4
`define IOPFR_ADDR_DN_BASE 16'h0D48
`define IOPFR_ADDR_SOL_MS_BASE 16'h0D7A
`define IOPFR_ADDR_SOL_S_BASE 16'h0D98
`define IOPFR_ADDR_SUPPLY_MV 16'h1388
`define IOPFR_ADDR_DRAW_MA 16'h1389
`define IOPFR_ADDR_TEMP 16'h138A
`define IOPFR_ADDR_IO_STATE 16'h138B

// ----------------------------------------------------------------
// Table span, widths and reset values
// ----------------------------------------------------------------
`define IOPFR_NTERM 16
`define IOPFR_W 16
`define IOPFR_TBL_SPAN 16'h0010
`define IOPFR_ZERO 16'h0000
`define IOPFR_ONES 16'hFFFF
`define IOPFR_RST_LOW_THR 16'h0000
`define IOPFR_RST_HIGH_THR 16'hFFFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IOPFR_MS_NS 1000000
`define IOPFR_CLK_NS 8
`define IOPFR_MS_CNT_W 17
`define IOPFR_MS_PER_S 1000
`define IOPFR_MS_LAST 10'h3E7

`endif

// ---- src/iopfr_pkg.sv ----
package iopfr_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [15:0] iopfr_word_t;
    typedef logic [9:0] iopfr_ms_t;
    typedef logic [4:0] iopfr_slot_t;

endpackage : iopfr_pkg

// ---- bench/iopfr_sva.sv ----
`timescale 1ns/1ps
module iopfr_sva
    import iopfr_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_exc,
    input wire logic [15:0] supply_mv,
    input wire logic current_sensor_present,
    input wire logic [15:0] temp_c,
    input wire logic [255:0] sol_pulse_ms,
    input wire logic [255:0] sol_onoff_s
);
    logic [3:0] pidx;
    logic [3:0] sidx;

    // Table entry addressed by the previous request
    always_ff @(posedge mclk) begin
        pidx <= 4'(reg_addr - 16'h0D7A);
        sidx <= 4'(reg_addr - 16'h0D98);
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    answer_next_a: assert property (
        (reg_wr || reg_rd) |=> (reg_ack ^ reg_exc))
        else $error("request not answered in one cycle");
    no_idle_answer_a: assert property (
        !(reg_wr || reg_rd) |=> !(reg_ack || reg_exc))
        else $error("answer without request");
    rdata_hold_a: assert property (
        !reg_ack |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    ro_write_refused_a: assert property (
        reg_wr && reg_addr inside {[16'h1388:16'h138B]} |=> reg_exc && !reg_ack)
        else $error("write to readout not refused");
    supply_read_a: assert property (
        reg_rd && reg_addr == 16'h1388 |=> reg_ack && reg_rdata == $past(supply_mv))
        else $error("supply readout wrong");
    draw_no_sensor_a: assert property (
        reg_rd && reg_addr == 16'h1389 && !current_sensor_present
        |=> reg_ack && reg_rdata == 16'h0000)
        else $error("draw without sensor not zero");
    temp_read_a: assert property (
        reg_rd && reg_addr == 16'h138A |=> reg_ack && reg_rdata == $past(temp_c))
        else $error("temperature readout wrong");
    pulse_table_a: assert property (
        reg_wr && reg_addr inside {[16'h0D7A:16'h0D89]}
        |=> reg_ack && sol_pulse_ms[{pidx, 4'h0} +: 16] == $past(reg_wdata))
        else $error("pulse table entry not written");
    onoff_table_a: assert property (
        reg_wr && reg_addr inside {[16'h0D98:16'h0DA7]}
        |=> reg_ack && sol_onoff_s[{sidx, 4'h0} +: 16] == $past(reg_wdata))
        else $error("on/off table entry not written");
endmodule : iopfr_sva

bind iopfr_bank iopfr_sva u_sva (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_exc(reg_exc), .supply_mv(supply_mv),
    .current_sensor_present(current_sensor_present), .temp_c(temp_c),
    .sol_pulse_ms(sol_pulse_ms), .sol_onoff_s(sol_onoff_s));

// ---- bench/iopfr_master.sv ----
`timescale 1ns/1ps
module iopfr_master (
    input wire logic mclk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_exc
);
    logic [15:0] last_data;
    logic [1:0] last_resp;

    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'hFFFF;
        reg_wdata = 16'hFFFF;
    end

    // One word; answer taken the cycle after, bus then scrambled
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] data);
        @(posedge mclk);
        #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = addr;
        reg_wdata = data;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
        last_data = reg_rdata;
        last_resp = {reg_exc, reg_ack};
    endtask : xfer

    // Mask then duration, back to back in one transaction
    task automatic pulse_pair(input logic [15:0] mask, input logic [15:0] dur);
        @(posedge mclk);
        #1;
        reg_wr = 1'b1;
        reg_addr = 16'h0A8C;
        reg_wdata = mask;
        @(posedge mclk);
        #1;
        reg_addr = 16'h0A8D;
        reg_wdata = dur;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_addr = 16'hF572;
        reg_wdata = ~dur;
        last_resp = {reg_exc, reg_ack};
    endtask : pulse_pair
endmodule : iopfr_master

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench
    import iopfr_pkg::*;
;
    localparam int MS = 10;
    logic mclk = 1'b0;
    logic reset_n, reg_wr, reg_rd, reg_ack, reg_exc, current_sensor_present;
    iopfr_word_t reg_addr, reg_wdata, reg_rdata, io_pin_in, io_out_req, io_is_output;
    iopfr_word_t solenoid_terms, supply_mv, draw_ma, temp_c, io_drive, mask, want, oc;
    logic [255:0] term_current_ma, sol_pulse_ms, sol_onoff_s;
    int fails = 0;
    int samples_checked = 0;
    int seed = 11846;

    iopfr_bank #(.MS_CYCLES(MS)) u_dut (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_exc(reg_exc), .io_pin_in(io_pin_in), .io_out_req(io_out_req),
        .io_is_output(io_is_output), .solenoid_terms(solenoid_terms),
        .term_current_ma(term_current_ma), .supply_mv(supply_mv), .draw_ma(draw_ma),
        .current_sensor_present(current_sensor_present), .temp_c(temp_c),
        .io_drive(io_drive), .sol_pulse_ms(sol_pulse_ms), .sol_onoff_s(sol_onoff_s));
    iopfr_master u_master (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_exc(reg_exc));

    // Clock, 8 ns period
    initial begin
        forever #4 mclk = ~mclk;
    end

    // Compare and count
    task automatic check(input iopfr_word_t got, input iopfr_word_t exp, input iopfr_word_t id);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: item %h got %h want %h", $time, id, got, exp);
        end
    endtask : check

    task automatic rd_chk(input iopfr_word_t addr, input iopfr_word_t exp);
        u_master.xfer(1'b0, addr, 16'h0000);
        check(u_master.last_data, exp, addr);
    endtask : rd_chk

    // Write one word and compare the answer kind (1 ack, 2 refused)
    task automatic wr(input iopfr_word_t addr, input iopfr_word_t data, input iopfr_word_t rsp);
        u_master.xfer(1'b1, addr, data);
        check(16'(u_master.last_resp), rsp, addr);
    endtask : wr

    // Expected fault log: solenoid terminals beyond threshold
    function automatic iopfr_word_t fault(input logic [255:0] cur, input iopfr_word_t sol,
        input iopfr_word_t thr, input logic hi);
        for (int n = 0; n < 16; n++) begin
            fault[n] = sol[n] && (hi ? cur[16*n +: 16] > thr : cur[16*n +: 16] < thr);
        end
    endfunction : fault

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog
    initial begin
        #400000;
        fails++;
        report_and_stop();
    end

    initial begin
        reset_n = 1'b0;
        io_pin_in = 16'h0000;
        io_out_req = 16'h0000;
        io_is_output = 16'hFFFF;
        solenoid_terms = 16'h0000;
        term_current_ma = '0;
        supply_mv = 16'h0000;
        draw_ma = 16'h0000;
        temp_c = 16'h0000;
        current_sensor_present = 1'b1;
        repeat (20) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        rd_chk(16'h0B58, 16'h0000);
        rd_chk(16'h0B59, 16'hFFFF);
        rd_chk(16'h0A8D, 16'h0000);
        // Solenoid tables, random words
        for (int n = 0; n < 16; n++) begin
            want = 16'($random(seed));
            wr(16'h0D7A + 16'(n), want, 16'h0001);
            rd_chk(16'h0D7A + 16'(n), want);
            check(sol_pulse_ms[16*n +: 16], want, 16'(n));
            wr(16'h0D98 + 16'(n), ~want, 16'h0001);
            rd_chk(16'h0D98 + 16'(n), ~want);
        end
        // Timed pulse, counting and expiry
        mask = 16'($random(seed)) | 16'h8001;
        u_master.pulse_pair(mask, 16'h0005);
        @(posedge mclk);
        #1;
        check(io_drive, mask, 16'h0A8C);
        rd_chk(16'h0A8D, 16'h0005);
        repeat (19) @(posedge mclk);
        rd_chk(16'h0A8D, 16'h0003);
        repeat (40) @(posedge mclk);
        check(io_drive, 16'h0000, 16'h0A8C);
        rd_chk(16'h0A8D, 16'h0000);
        io_out_req = 16'hFFFF;
        u_master.pulse_pair(mask, 16'h0000);
        @(posedge mclk);
        #1;
        check(io_drive, ~mask, 16'h0A8D);
        u_master.pulse_pair(16'h0000, 16'h0000);
        // Current faults on random solenoid terminals
        solenoid_terms = 16'($random(seed));
        for (int n = 0; n < 16; n++) begin
            term_current_ma[16*n +: 16] = 16'(($random(seed) & 3) * 300);
        end
        wr(16'h0B58, 16'd100, 16'h0001);
        wr(16'h0B59, 16'd700, 16'h0001);
        repeat (3) @(posedge mclk);
        want = fault(term_current_ma, solenoid_terms, 16'd100, 1'b0);
        oc = fault(term_current_ma, solenoid_terms, 16'd700, 1'b1);
        rd_chk(16'h0B57, want);
        rd_chk(16'h0B55, want);
        rd_chk(16'h0B56, oc);
        rd_chk(16'h0B54, want | oc);
        term_current_ma = {16{16'd300}};
        repeat (3) @(posedge mclk);
        rd_chk(16'h0B57, 16'h0000);
        rd_chk(16'h0B56, oc);
        wr(16'h0B56, 16'h00FF, 16'h0001);
        rd_chk(16'h0B56, oc & 16'hFF00);
        wr(16'h0B54, 16'hFFFF, 16'h0001);
        rd_chk(16'h0B54, oc & 16'hFF00);
        // Readouts, refusals
        supply_mv = 16'($random(seed));
        draw_ma = 16'($random(seed));
        temp_c = 16'hFFF6;
        rd_chk(16'h1388, supply_mv);
        rd_chk(16'h1389, draw_ma);
        rd_chk(16'h138A, temp_c);
        current_sensor_present = 1'b0;
        rd_chk(16'h1389, 16'h0000);
        wr(16'h1388, 16'h1234, 16'h0002);
        wr(16'h0000, 16'h1234, 16'h0002);
        // Merged state of inputs and outputs
        io_is_output = 16'h00FF;
        io_out_req = 16'($random(seed));
        io_pin_in = 16'($random(seed));
        repeat (4) @(posedge mclk);
        rd_chk(16'h138B, (io_out_req & 16'h00FF) | (io_pin_in & 16'hFF00));
        // Second timers on terminals 0 (high) and 1 (low)
        io_is_output = 16'h0000;
        io_pin_in = 16'h0001;
        repeat (4) @(posedge mclk);
        wr(16'h0CE4, 16'h0000, 16'h0001);
        wr(16'h0D49, 16'h0000, 16'h0001);
        repeat (100 * MS + 10000) @(posedge mclk);
        rd_chk(16'h0CE4, 16'h0001);
        rd_chk(16'h0D49, 16'h0001);
        rd_chk(16'h0D48, 16'h0000);
        wr(16'h0CE4, 16'h0000, 16'h0001);
        rd_chk(16'h0CE4, 16'h0000);
        report_and_stop();
    end
endmodule : testbench
